// *** shared/apnms_pkg.sv ***
// Package: register map, field positions, command codes and mode encodings of the preset block
package apnms_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] OFF_OPERATION_CONTROL  = 8'h02;
  localparam logic [7:0] OFF_TYPE_A_FRAMING     = 8'h05;
  localparam logic [7:0] OFF_AUXILIARY_DEF      = 8'h09;
  localparam logic [7:0] OFF_RECEIVER_CFG_ONE   = 8'h0a;
  localparam logic [7:0] OFF_RECEIVER_CFG_THREE = 8'h0c;
  localparam logic [7:0] OFF_MODE_DEFINITION    = 8'h20;
  localparam logic [7:0] OFF_BIT_RATE_DEF       = 8'h21;
  localparam logic [7:0] OFF_RATE_DETECT_SHOW   = 8'h22;
  localparam logic [7:0] OFF_COMMAND            = 8'h23;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_SINGLE_RX_CHANNEL  = 5;
  localparam int BIT_TX_ENABLE          = 3;
  localparam int BIT_START_BYTE_FRAMING = 5;
  localparam int BIT_MODULATION_TYPE    = 5;
  localparam int BIT_FIELD_DETECTOR_EN  = 4;
  localparam int BIT_DEMOD_CHANNEL      = 7;
  localparam int BIT_AM_DEMOD_CHOICE    = 6;
  localparam int POS_FILTER_CODE        = 0;  // Lowpass bits 5:3, zero bits 2:0
  localparam int BIT_STAGE_CLIP         = 1;
  localparam int BIT_FORCED_GAIN_CUT    = 0;
  localparam int BIT_MODE_TARGET        = 0;  // Mode definition: target role
  localparam int POS_MODE_CODE          = 4;  // Mode definition: code in bits 7:4
  localparam int POS_TX_RATE            = 4;  // Bit rate: tx in 7:4, rx in 3:0

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_OPERATION_CONTROL  = 8'h00;
  localparam logic [7:0] RST_TYPE_A_FRAMING     = 8'h00;
  localparam logic [7:0] RST_AUXILIARY_DEF      = 8'h00;
  localparam logic [7:0] RST_RECEIVER_CFG_ONE   = 8'h00;
  localparam logic [7:0] RST_RECEIVER_CFG_THREE = 8'h00;
  localparam logic [7:0] RST_MODE_DEFINITION    = 8'h10;
  localparam logic [7:0] RST_BIT_RATE_DEF       = 8'h00;

  // ****************************************************************
  // Commands, modes and rates
  // ****************************************************************
  localparam logic [7:0] CMD_GO_NORMAL_NFC = 8'h01;
  localparam logic [7:0] CMD_ANALOG_PRESET = 8'h02;
  localparam logic [3:0] RATE_106          = 4'h0;

  typedef enum logic [3:0] {
    APNMS_MODE_TYPE_A     = 4'h1,
    APNMS_MODE_TYPE_B     = 4'h2,
    APNMS_MODE_VICINITY   = 4'h3,
    APNMS_MODE_TYPE_F     = 4'h4,
    APNMS_MODE_NFCIP1     = 4'h5,
    APNMS_MODE_SUBC_STRM  = 4'h6,
    APNMS_MODE_BPSK_STRM  = 4'h7,
    APNMS_MODE_RATE_DETECT = 4'h8
  } apnms_mode_t;

  // Register port request, one beat per cycle
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } apnms_req_t;

endpackage

// *** src/apnms_core.sv ***
// Design: go-to-normal NFC and analog preset command logic with its register file
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Go-to-normal command leaves bit-rate detection mode for normal NFC mode.
// - Go-to-normal copies detected rate into bit-rate register, fixes modulation bit.
// - Analog preset sets receiver and transmitter bits from mode and bit rate.
// - Preset sets single receive channel bit for NFCIP-1 active communication.
// - Preset clears transmitter enable in target modes and NFCIP-1 initiator.
// - In NFCIP-1 the preset never switches the transmitter field on.
// - Preset sets start-byte framing bit for NFCIP-1 active communication.
// - Preset picks OOK for Type A and 106k NFCIP-1, AM for Type B, Type F and faster NFCIP-1; other modes keep the bit.
// - Preset enables field detector only for NFCIP-1 active communication.
// - Preset selects AM demodulation channel for NFCIP-1 active communication.
// - Preset sets AM demodulator choice from receive bit rate.
// - Preset loads three low-pass bits from mode and receive rate.
// - Preset loads three zero-setting bits from mode and receive rate.
// - Preset sets stage clipping only for NFCIP-1 active communication.
// - Preset sets forced gain cut only for NFCIP-1 active communication.
module apnms_core
  import apnms_pkg::*;
#(
  parameter int RATE_W = 4
)
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire apnms_pkg::apnms_req_t bus_req,
  output logic [7:0]                 bus_rdata,
  input  wire logic [RATE_W-1:0]     detected_rate,
  input  wire logic [5:0]            filter_code,
  output logic [7:0]                 operation_control,
  output logic [7:0]                 type_a_framing_settings,
  output logic [7:0]                 auxiliary_definition,
  output logic [7:0]                 receiver_config_one,
  output logic [7:0]                 receiver_config_three,
  output logic [7:0]                 mode_definition,
  output logic [7:0]                 bit_rate_definition
);
  import apnms_pkg::*;

  logic [7:0]  op_ctl_q;
  logic [7:0]  framing_q;
  logic [7:0]  aux_q;
  logic [7:0]  rx_one_q;
  logic [7:0]  rx_three_q;
  logic [7:0]  mode_q;
  logic [7:0]  rate_q;
  logic [7:0]  rdata_q;
  logic [7:0]  rate_show;
  logic [3:0]  rate_nib;
  logic        go_normal;
  logic        preset;
  logic        is_nfcip;
  logic        is_target;
  logic        is_stream;
  logic [3:0]  mode_code;
  logic [3:0]  tx_rate;
  logic [3:0]  rx_rate;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Write strobe hit on one register offset
  function automatic logic wr_hit(input apnms_req_t r, input logic [7:0] off);
    wr_hit = r.wr && (r.addr == off);
  endfunction

  // Any rate above 106k uses amplitude modulation
  function automatic logic rate_is_am(input logic [3:0] rate);
    rate_is_am = (rate != RATE_106);
  endfunction

  // ****************************************************************
  // Command decode and mode view
  // ****************************************************************

  // Commands are single writes to the command offset
  assign go_normal = wr_hit(bus_req, OFF_COMMAND) && (bus_req.wdata == CMD_GO_NORMAL_NFC);
  assign mode_code = mode_q[POS_MODE_CODE +: 4];
  assign tx_rate   = rate_q[POS_TX_RATE +: 4];
  assign rx_rate   = rate_q[3:0];
  assign is_nfcip  = (mode_code == APNMS_MODE_NFCIP1);
  assign is_target = mode_q[BIT_MODE_TARGET];
  // Stream modes have no defined preset, so the command is dropped there
  assign is_stream = (mode_code == APNMS_MODE_SUBC_STRM) || (mode_code == APNMS_MODE_BPSK_STRM);
  assign preset    = wr_hit(bus_req, OFF_COMMAND) && (bus_req.wdata == CMD_ANALOG_PRESET) && !is_stream;
  // Detected rate shown on both nibbles so one copy fills tx and rx rates
  assign rate_nib  = 4'(detected_rate); // Zero-extends a narrower detector code
  assign rate_show = {rate_nib, rate_nib};

  // ****************************************************************
  // Operation control
  // ****************************************************************

  // Transmitter is only ever cleared here; field-on is left to its own commands
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      op_ctl_q <= RST_OPERATION_CONTROL;
    else if (wr_hit(bus_req, OFF_OPERATION_CONTROL))
      op_ctl_q <= bus_req.wdata;
    else if (preset)
    begin
      if (is_nfcip)
        op_ctl_q[BIT_SINGLE_RX_CHANNEL] <= 1'b1;
      if (is_target || is_nfcip)
        op_ctl_q[BIT_TX_ENABLE] <= 1'b0;
    end
  end

  // ****************************************************************
  // Type A framing settings
  // ****************************************************************

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      framing_q <= RST_TYPE_A_FRAMING;
    else if (wr_hit(bus_req, OFF_TYPE_A_FRAMING))
      framing_q <= bus_req.wdata;
    else if (preset && is_nfcip)
      framing_q[BIT_START_BYTE_FRAMING] <= 1'b1;
  end

  // ****************************************************************
  // Auxiliary definition
  // ****************************************************************

  // Modulation type follows the rate just copied or the current mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      aux_q <= RST_AUXILIARY_DEF;
    else if (wr_hit(bus_req, OFF_AUXILIARY_DEF))
      aux_q <= bus_req.wdata;
    else if (go_normal)
      aux_q[BIT_MODULATION_TYPE] <= rate_is_am(rate_show[POS_TX_RATE +: 4]);
    else if (preset)
    begin
      aux_q[BIT_FIELD_DETECTOR_EN] <= is_nfcip;
      unique case (mode_code)
        APNMS_MODE_TYPE_A: aux_q[BIT_MODULATION_TYPE] <= 1'b0;
        APNMS_MODE_TYPE_B: aux_q[BIT_MODULATION_TYPE] <= 1'b1;
        APNMS_MODE_TYPE_F: aux_q[BIT_MODULATION_TYPE] <= 1'b1;
        APNMS_MODE_NFCIP1: aux_q[BIT_MODULATION_TYPE] <= rate_is_am(tx_rate);
        default:           aux_q[BIT_MODULATION_TYPE] <= aux_q[BIT_MODULATION_TYPE]; // Vicinity keeps it
      endcase
    end
  end

  // ****************************************************************
  // Receiver configuration one
  // ****************************************************************

  // Filter code comes from the external selection table for this mode and rx rate
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_one_q <= RST_RECEIVER_CFG_ONE;
    else if (wr_hit(bus_req, OFF_RECEIVER_CFG_ONE))
      rx_one_q <= bus_req.wdata;
    else if (preset)
    begin
      if (is_nfcip)
        rx_one_q[BIT_DEMOD_CHANNEL] <= 1'b0;
      rx_one_q[BIT_AM_DEMOD_CHOICE]   <= rate_is_am(rx_rate);
      rx_one_q[POS_FILTER_CODE +: 6]  <= filter_code;
    end
  end

  // ****************************************************************
  // Receiver configuration three
  // ****************************************************************

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rx_three_q <= RST_RECEIVER_CFG_THREE;
    else if (wr_hit(bus_req, OFF_RECEIVER_CFG_THREE))
      rx_three_q <= bus_req.wdata;
    else if (preset)
    begin
      rx_three_q[BIT_STAGE_CLIP]      <= is_nfcip;
      rx_three_q[BIT_FORCED_GAIN_CUT] <= is_nfcip;
    end
  end

  // ****************************************************************
  // Mode and bit rate definition
  // ****************************************************************

  // Leaving detection puts the block in NFCIP-1 target mode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      mode_q <= RST_MODE_DEFINITION;
    else if (wr_hit(bus_req, OFF_MODE_DEFINITION))
      mode_q <= bus_req.wdata;
    else if (go_normal && (mode_code == APNMS_MODE_RATE_DETECT))
    begin
      mode_q[POS_MODE_CODE +: 4]  <= APNMS_MODE_NFCIP1;
      mode_q[BIT_MODE_TARGET]     <= 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rate_q <= RST_BIT_RATE_DEF;
    else if (wr_hit(bus_req, OFF_BIT_RATE_DEF))
      rate_q <= bus_req.wdata;
    else if (go_normal)
      rate_q <= rate_show;
  end

  // ****************************************************************
  // Read port
  // ****************************************************************

  // Data stand one cycle after the strobe; unmapped offsets and the command read zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      rdata_q <= 8'h00;
    else if (bus_req.rd)
    begin
      unique case (bus_req.addr)
        OFF_OPERATION_CONTROL:  rdata_q <= op_ctl_q;
        OFF_TYPE_A_FRAMING:     rdata_q <= framing_q;
        OFF_AUXILIARY_DEF:      rdata_q <= aux_q;
        OFF_RECEIVER_CFG_ONE:   rdata_q <= rx_one_q;
        OFF_RECEIVER_CFG_THREE: rdata_q <= rx_three_q;
        OFF_MODE_DEFINITION:    rdata_q <= mode_q;
        OFF_BIT_RATE_DEF:       rdata_q <= rate_q;
        OFF_RATE_DETECT_SHOW:   rdata_q <= rate_show;
        default:                rdata_q <= 8'h00;
      endcase
    end
    else
      rdata_q <= 8'h00;
  end

  // No completion interrupt exists, both commands finish in the write cycle
  assign bus_rdata               = rdata_q;
  assign operation_control       = op_ctl_q;
  assign type_a_framing_settings = framing_q;
  assign auxiliary_definition    = aux_q;
  assign receiver_config_one     = rx_one_q;
  assign receiver_config_three   = rx_three_q;
  assign mode_definition         = mode_q;
  assign bit_rate_definition     = rate_q;

endmodule

`default_nettype wire

// *** testbench/apnms_properties.sv ***
// Checker: concurrent properties of the preset and go-to-normal commands
`timescale 1ns/100ps
`default_nettype none
module apnms_properties
  import apnms_pkg::*;
#(
  parameter int RATE_W = 4
)
(
  input wire logic                  clk,
  input wire logic                  rst,
  input wire apnms_pkg::apnms_req_t bus_req,
  input wire logic [7:0]            bus_rdata,
  input wire logic [RATE_W-1:0]     detected_rate,
  input wire logic [5:0]            filter_code,
  input wire logic [7:0]            operation_control,
  input wire logic [7:0]            type_a_framing_settings,
  input wire logic [7:0]            auxiliary_definition,
  input wire logic [7:0]            receiver_config_one,
  input wire logic [7:0]            receiver_config_three,
  input wire logic [7:0]            mode_definition,
  input wire logic [7:0]            bit_rate_definition
);
  import apnms_pkg::*;

  // ****************************************
  // Command decode
  // ****************************************
  logic cmd_w;
  logic nfc;
  logic pre;
  logic gon;
  // Stream modes 6 and 7 share bits 7:5, so the preset is ignored there
  assign cmd_w = bus_req.wr && bus_req.addr == OFF_COMMAND;
  assign nfc   = mode_definition[7:4] == 4'h5;
  assign pre   = cmd_w && bus_req.wdata == CMD_ANALOG_PRESET && mode_definition[7:5] != 3'h3;
  assign gon   = cmd_w && bus_req.wdata == CMD_GO_NORMAL_NFC;

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************
  // Properties
  // ****************************************
  a_leave_detect: assert property (gon && mode_definition[7:4] == 4'h8
    |=> mode_definition == {4'h5, $past(mode_definition[3:1]), 1'b1}) else $error("go-normal did not enter active mode");
  a_rate_copy: assert property (gon |=> bit_rate_definition == {2{$past(detected_rate)}}
    && auxiliary_definition[5] == ($past(detected_rate) != 0)) else $error("rate copy wrong");
  a_single_channel: assert property (pre && nfc |=> operation_control[5])
    else $error("single channel bit not set");
  a_tx_disable: assert property (pre && (nfc || mode_definition[0]) |=> !operation_control[3])
    else $error("transmitter left on");
  a_framing_bit: assert property (pre && nfc |=> type_a_framing_settings[5])
    else $error("framing bit not set");
  a_ook_type_a: assert property (pre && mode_definition[7:4] == 4'h1 |=> !auxiliary_definition[5])
    else $error("type A not OOK");
  a_field_detect: assert property (pre |=> auxiliary_definition[4] == $past(nfc))
    else $error("field detector enable wrong");
  a_am_channel: assert property (pre && nfc |=> !receiver_config_one[7])
    else $error("AM channel not chosen");
  a_demod_choice: assert property (pre |=> receiver_config_one[6] == ($past(bit_rate_definition[3:0]) != 0))
    else $error("demodulator choice wrong");
  a_filter_load: assert property (pre |=> receiver_config_one[5:0] == $past(filter_code))
    else $error("filter code not loaded");
  a_clip_gain: assert property (pre |=> receiver_config_three[1:0] == {2{$past(nfc)}})
    else $error("clip or gain cut wrong");
  a_keep_bits: assert property (pre |=> $stable(receiver_config_three[7:2]) && $stable(auxiliary_definition[3:0]))
    else $error("bits outside preset group changed");
  a_rdata_clear: assert property (!$past(bus_req.rd) |-> bus_rdata == 8'h00)
    else $error("read data left standing");

  c_preset_nfc: cover property (pre && nfc);
  c_preset_target: cover property (pre && mode_definition[0]);
  c_leave_detect: cover property (gon && mode_definition[7:4] == 4'h8);
endmodule

bind apnms_core apnms_properties #(.RATE_W(RATE_W)) u_props (.clk(clk), .rst(rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .detected_rate(detected_rate), .filter_code(filter_code),
  .operation_control(operation_control), .type_a_framing_settings(type_a_framing_settings),
  .auxiliary_definition(auxiliary_definition), .receiver_config_one(receiver_config_one),
  .receiver_config_three(receiver_config_three), .mode_definition(mode_definition),
  .bit_rate_definition(bit_rate_definition));
`default_nettype wire

// *** testbench/tb_apnms_core.sv ***
// Testbench: self-checking bench for the preset and go-to-normal commands
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_apnms_core;
  import apnms_pkg::*;
  typedef struct packed {
    logic [15:0] mb;
    logic [5:0]  fc;
    logic [39:0] ex;
  } apnms_row_t;
  // Mode and rate, filter code, then expected op, framing, aux, rx1, rx3
  localparam apnms_row_t ROWS [6] = '{
    '{16'h1000, 6'h15, 40'h080f0095fc}, '{16'h2011, 6'h2a, 40'h080f20eafc},
    '{16'h4122, 6'h07, 40'h000f20c7fc}, '{16'h5000, 6'h38, 40'h202f1038ff},
    '{16'h5121, 6'h01, 40'h202f3041ff}, '{16'h3000, 6'h3f, 40'h080f20bffc}};
  // Preload pattern: tx on, channel select set, upper clip bits set
  localparam logic [39:0] PO = 40'h0205090a0c;
  localparam logic [39:0] PV = 40'h080f2080fc;
  logic       clk;
  logic       rst;
  apnms_req_t req;
  logic [7:0] rdata;
  logic [3:0] det;
  logic [5:0] filt;
  logic [7:0] op, ty, ax, r1, r3, md, br;
  int         bad_count;
  int         checks;

  apnms_core DUT (.clk(clk), .rst(rst), .bus_req(req), .bus_rdata(rdata), .detected_rate(det),
    .filter_code(filt), .operation_control(op), .type_a_framing_settings(ty), .auxiliary_definition(ax),
    .receiver_config_one(r1), .receiver_config_three(r3), .mode_definition(md), .bit_rate_definition(br));

  // ****************************************
  // Bus tasks and report
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
  endtask
  // Lands one step past the edge, so register updates are settled
  task automatic idle();
    @(posedge clk);
    req <= '{8'h00, 8'h00, 1'b0, 1'b0};
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    idle();
    `CHK(rdata, e)
  endtask
  task automatic preload();
    for (int k = 0; k < 5; k++)
      wr(PO[8*(4-k)+:8], PV[8*(4-k)+:8]);
  endtask
  task automatic test_done();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Bounds the whole run in case the bench stalls
  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    test_done();
  end
  initial
  begin
    rst = 1'b1;
    req = '0;
    det = 4'h0;
    filt = 6'h00;
    bad_count = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    `CHK({md, op, ty, ax, r1, r3, br}, {RST_MODE_DEFINITION, 48'h0})
    `CHK(rdata, 8'h00)
    foreach (ROWS[i])
    begin
      preload();
      filt <= ROWS[i].fc;
      wr(OFF_MODE_DEFINITION, ROWS[i].mb[15:8]);
      wr(OFF_BIT_RATE_DEF, ROWS[i].mb[7:0]);
      wr(OFF_COMMAND, CMD_ANALOG_PRESET);
      idle();
      `CHK({op, ty}, ROWS[i].ex[39:24])
      `CHK(ax, ROWS[i].ex[23:16])
      `CHK({r1, r3}, ROWS[i].ex[15:0])
      rd(OFF_RECEIVER_CFG_ONE, ROWS[i].ex[15:8]);
    end
    // Stream modes: the preset must leave every register alone
    for (int m = 6; m < 8; m++)
    begin
      preload();
      wr(OFF_MODE_DEFINITION, {m[3:0], 4'h1});
      wr(OFF_COMMAND, CMD_ANALOG_PRESET);
      idle();
      `CHK({op, ty, ax, r1, r3}, PV)
    end
    wr(OFF_MODE_DEFINITION, 8'h80);
    det <= 4'h2;
    wr(OFF_COMMAND, CMD_GO_NORMAL_NFC);
    idle();
    `CHK({md, br, ax[5]}, {16'h5122, 1'b1})
    rd(OFF_RATE_DETECT_SHOW, 8'h22);
    // Go-normal outside detect mode keeps the mode but still copies the rate
    wr(OFF_MODE_DEFINITION, 8'h10);
    det <= 4'h0;
    wr(OFF_COMMAND, CMD_GO_NORMAL_NFC);
    idle();
    `CHK({md, br, ax[5]}, {16'h1000, 1'b0})
    // Back-to-back commands: preset sees the mode set one cycle earlier
    wr(OFF_MODE_DEFINITION, 8'h80);
    det <= 4'h1;
    wr(OFF_COMMAND, CMD_GO_NORMAL_NFC);
    wr(OFF_COMMAND, CMD_ANALOG_PRESET);
    idle();
    `CHK({md, br, r3[1:0], ty[5]}, {16'h5111, 3'h7})
    wr(8'h3f, 8'hff);
    rd(8'h3f, 8'h00);
    wr(OFF_RATE_DETECT_SHOW, 8'h00);
    rd(OFF_RATE_DETECT_SHOW, 8'h11);
    rd(OFF_COMMAND, 8'h00);
    idle();
    `CHK(rdata, 8'h00)
    test_done();
  end
endmodule
`default_nettype wire
